// ==== lidc_checks.sv ====
// Exception checks for legacy port instructions and the legacy debug model.
// Assumes one request pulse per instruction and a fabric that answers with accept.
// Notes on behaviour
// - Grant port access when privilege within limit.
// - Else consult bitmap; any denied bit faults.
// - Bitmap disabled: no segment read, fault.
// - Port address built relative to space base.
// - Base or port high bits shifted, low bits.
// - Translation on: missing mapping raises miss fault.
// - Translation on: check rights, keys, status bits.
// - Translation off or unimplemented address faults.
// - Data breakpoints trap; alignment fault when enabled.
// - Split accesses crossing a four-port boundary.
// - Port instructions ordered; wait for acceptance.
// - Plain loads and stores skip port checks, waits.
// - Single step traps after each legacy instruction.
// - Breakpoint interrupt instruction always traps.
// - Instruction breakpoint fault needs enable, no suppress.
// - Suppress bits cleared by successful execution.
// - Data breakpoints trap, report first four matches.
// - Taken branch traps, pointer at target.
// - Lower-privilege transfer trap never raised.
// - Any masked accessed byte matches; upper bits zero.
// - Data mask bits above 31 compared.
// - Match needs enable, privilege, debug, no fault.
// - Instruction match: first byte, low mask, conditions.
`include "lidc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lidc_checks (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Processor state.
    input wire logic [`LIDC_PL_W-1:0] current_privilege_level,
    input wire logic [`LIDC_PL_W-1:0] io_privilege_level,
    input wire logic io_bitmap_enable,
    input wire logic [`LIDC_VA_W-1:0] io_space_base,
    input wire logic data_translation_enable,
    input wire logic alignment_check_enable,
    input wire logic single_step_enable,
    input wire logic legacy_trap_flag,
    input wire logic debug_enable,
    input wire logic taken_branch_trap_enable,
    // Breakpoint registers, flattened by index.
    input wire logic [`LIDC_NBRK*`LIDC_VA_W-1:0] data_bp_addr,
    input wire logic [`LIDC_NBRK*`LIDC_VA_W-1:0] data_bp_mask,
    input wire logic [`LIDC_NBRK-1:0] data_bp_rd_en,
    input wire logic [`LIDC_NBRK-1:0] data_bp_wr_en,
    input wire logic [`LIDC_NBRK*`LIDC_PL_W-1:0] data_bp_plv,
    input wire logic [`LIDC_NBRK*`LIDC_VA_W-1:0] instr_bp_addr,
    input wire logic [`LIDC_NBRK*`LIDC_VA_W-1:0] instr_bp_mask,
    input wire logic [`LIDC_NBRK-1:0] instr_bp_x_en,
    input wire logic [`LIDC_NBRK*`LIDC_PL_W-1:0] instr_bp_plv,
    // Legacy instruction fetch and retirement.
    input wire logic fetch_valid,
    input wire logic [`LIDC_VA_W-1:0] fetch_addr,
    input wire logic retire_legacy,
    input wire logic retire_native,
    input wire logic retire_break3,
    input wire logic retire_taken_branch,
    input wire logic [`LIDC_VA_W-1:0] next_ip,
    input wire logic [`LIDC_VA_W-1:0] branch_target,
    input wire logic set_instr_debug_suppress,
    input wire logic set_legacy_resume_flag,
    // Port or memory access request.
    input wire logic acc_req,
    input wire logic acc_is_port,
    input wire logic acc_write,
    input wire logic [`LIDC_PORT_W-1:0] acc_port,
    input wire logic [`LIDC_VA_W-1:0] acc_vaddr,
    input wire logic [2:0] acc_len,
    // Bitmap read answer from the task_state_segment.
    input wire logic bitmap_deny,
    // Translation answer.
    input wire logic tlb_hit,
    input wire logic hpt_walk_en,
    input wire logic addr_implemented,
    input wire logic tlb_prot_ok,
    // Fabric answer.
    input wire logic fabric_accept,
    // Bitmap lookup request.
    output logic bitmap_rd,
    // Transaction to the fabric.
    output logic fab_valid,
    output logic [`LIDC_VA_W-1:0] fab_addr,
    output logic [2:0] fab_len,
    output logic fab_write,
    output logic acc_busy,
    // Exception report.
    output logic exc_valid,
    output lidc_pkg::lidc_exc_t exc_kind,
    output logic [7:0] exc_vector,
    output logic [`LIDC_NBRK-1:0] exc_trap_bits,
    output logic [`LIDC_VA_W-1:0] interruption_instr_pointer,
    output logic lower_priv_trap,
    output logic instr_debug_suppress,
    output logic legacy_resume_flag
);
    logic [`LIDC_VA_W-1:0] port_va;
    logic priv_ok, idle, ibrk;
    logic [`LIDC_PORT_W-1:0] nport;
    logic [`LIDC_NBRK-1:0] d_hit, i_hit, d_fire, i_fire;
    logic misaligned, crosses;
    lidc_pkg::lidc_exc_t pre_exc;
    logic [2:0] first_len;
    lidc_pkg::lidc_state_t st_q, st_d;
    logic [`LIDC_VA_W-1:0] rem_addr_q, rem_addr_d, fab_addr_q, fab_addr_d;
    logic [2:0] rem_len_q, rem_len_d, fab_len_q, fab_len_d;
    logic fab_write_q, fab_write_d;
    logic id_q, id_d, rf_q, rf_d;
    logic exc_valid_q, exc_valid_d;
    lidc_pkg::lidc_exc_t exc_kind_q, exc_kind_d;
    logic [7:0] exc_vec_q, exc_vec_d;
    logic [`LIDC_NBRK-1:0] trap_bits_q, trap_bits_d;
    logic [`LIDC_VA_W-1:0] iip_q, iip_d;

    // Port virtual address: base, port high bits per page, low bits as page offset.
    assign port_va = io_space_base
                   | ({{(`LIDC_VA_W-14){1'b0}}, acc_port[`LIDC_PORT_W-1:`LIDC_PORT_HI_LSB]} << `LIDC_PAGE_SHIFT)
                   | {{(`LIDC_VA_W-12){1'b0}}, acc_port[`LIDC_PORT_LO_MSB:0]};

    // Privilege test for port instructions.
    assign priv_ok = (current_privilege_level <= io_privilege_level);

    // Idle sequencer; a fetch that takes an instruction breakpoint.
    assign idle = (st_q == lidc_pkg::LIDC_ST_IDLE);
    assign ibrk = fetch_valid && (|i_fire);

    // Bitmap is read only when privilege fails and the bitmap is enabled.
    assign bitmap_rd = acc_req && acc_is_port && !priv_ok && io_bitmap_enable && idle;

    // Alignment and four-port crossing.
    assign crosses = ({1'b0, acc_port[1:0]} + acc_len) > 3'd4;
    assign misaligned = (acc_len == 3'd2 && acc_port[0]) || (acc_len == 3'd4 && acc_port[1:0] != 2'b00);
    assign first_len = crosses ? 3'(3'd4 - {1'b0, acc_port[1:0]}) : acc_len;
    assign nport = acc_port + 16'(first_len);

    // Breakpoint comparators, one per register.
    genvar gi;
    generate
        for (gi = 0; gi < `LIDC_NBRK; gi = gi + 1) begin : g_bp
            lidc_brk_match u_dbm (
                .bp_addr(data_bp_addr[gi*`LIDC_VA_W +: `LIDC_VA_W]),
                .bp_mask(data_bp_mask[gi*`LIDC_VA_W +: `LIDC_VA_W]),
                .acc_addr(acc_is_port ? port_va : acc_vaddr),
                .acc_len(acc_len),
                .is_instr(1'b0),
                .hit(d_hit[gi])
            );
            lidc_brk_match u_ibm (
                .bp_addr(instr_bp_addr[gi*`LIDC_VA_W +: `LIDC_VA_W]),
                .bp_mask(instr_bp_mask[gi*`LIDC_VA_W +: `LIDC_VA_W]),
                .acc_addr(fetch_addr),
                .acc_len(3'd1),
                .is_instr(1'b1),
                .hit(i_hit[gi])
            );
            assign d_fire[gi] = d_hit[gi] && debug_enable
                && (acc_write ? data_bp_wr_en[gi] : data_bp_rd_en[gi])
                && (data_bp_plv[gi*`LIDC_PL_W +: `LIDC_PL_W] == current_privilege_level)
                && (pre_exc == lidc_pkg::LIDC_EXC_NONE);
            assign i_fire[gi] = i_hit[gi] && instr_bp_x_en[gi] && debug_enable && !id_q && !rf_q
                && (instr_bp_plv[gi*`LIDC_PL_W +: `LIDC_PL_W] == current_privilege_level);
        end
    endgenerate

    // Fault priority for an access: permission, translation, protection, alignment.
    always_comb begin
        pre_exc = lidc_pkg::LIDC_EXC_NONE;
        if (acc_is_port && !priv_ok && (!io_bitmap_enable || bitmap_deny)) begin
            pre_exc = lidc_pkg::LIDC_EXC_GP;
        end else if (acc_is_port && (!data_translation_enable || !addr_implemented)) begin
            pre_exc = lidc_pkg::LIDC_EXC_GP;
        end else if (data_translation_enable && !tlb_hit) begin
            pre_exc = hpt_walk_en ? lidc_pkg::LIDC_EXC_HPT_MISS :
                      (acc_is_port ? lidc_pkg::LIDC_EXC_DTLB_MISS : lidc_pkg::LIDC_EXC_ALT_DTLB_MISS);
        end else if (data_translation_enable && !tlb_prot_ok) begin
            pre_exc = lidc_pkg::LIDC_EXC_PROT;
        end else if (alignment_check_enable && misaligned) begin
            pre_exc = lidc_pkg::LIDC_EXC_ALIGN;
        end
    end

    // Port sequencer and exception report, next values.
    always_comb begin
        st_d = st_q;
        rem_addr_d = rem_addr_q;
        rem_len_d = rem_len_q;
        fab_addr_d = fab_addr_q;
        fab_len_d = fab_len_q;
        fab_write_d = fab_write_q;
        exc_valid_d = 1'b0;
        exc_kind_d = exc_kind_q;
        exc_vec_d = exc_vec_q;
        trap_bits_d = trap_bits_q;
        iip_d = iip_q;
        id_d = id_q;
        rf_d = rf_q;
        // Suppress bits: set by software, cleared by successful execution.
        if (retire_legacy) begin
            id_d = 1'b0;
            rf_d = 1'b0;
        end else if (retire_native) begin
            id_d = 1'b0;
        end
        if (set_instr_debug_suppress) begin
            id_d = 1'b1;
        end
        if (set_legacy_resume_flag) begin
            rf_d = 1'b1;
        end
        unique case (st_q)
            lidc_pkg::LIDC_ST_IDLE: begin
                if (ibrk) begin
                    exc_valid_d = 1'b1;
                    exc_kind_d = lidc_pkg::LIDC_EXC_IBRK;
                    exc_vec_d = `LIDC_VEC_DEBUG;
                    trap_bits_d = '0;
                    iip_d = fetch_addr;
                end else if (acc_req && pre_exc != lidc_pkg::LIDC_EXC_NONE) begin
                    exc_valid_d = 1'b1;
                    exc_kind_d = pre_exc;
                    exc_vec_d = (pre_exc == lidc_pkg::LIDC_EXC_GP) ? `LIDC_VEC_GP :
                                (pre_exc == lidc_pkg::LIDC_EXC_ALIGN) ? `LIDC_VEC_ALIGN : `LIDC_VEC_NONE;
                    trap_bits_d = '0;
                end else if (acc_req) begin
                    trap_bits_d = trap_bits_q | d_fire;
                    fab_write_d = acc_write;
                    if (acc_is_port) begin
                        fab_addr_d = port_va;
                        fab_len_d = first_len;
                        rem_addr_d = io_space_base | (`LIDC_VA_W'(nport[`LIDC_PORT_W-1:`LIDC_PORT_HI_LSB]) << `LIDC_PAGE_SHIFT)
                                     | `LIDC_VA_W'(nport[`LIDC_PORT_LO_MSB:0]);
                        rem_len_d = 3'(acc_len - first_len);
                        st_d = lidc_pkg::LIDC_ST_WAIT;
                    end else begin
                        fab_addr_d = acc_vaddr;
                        fab_len_d = acc_len;
                        st_d = lidc_pkg::LIDC_ST_ISSUE;
                    end
                end else if (retire_legacy) begin
                    if (retire_break3) begin
                        exc_valid_d = 1'b1;
                        exc_vec_d = `LIDC_VEC_BREAK;
                        iip_d = next_ip;
                    end else if (taken_branch_trap_enable && retire_taken_branch) begin
                        exc_valid_d = 1'b1;
                        exc_vec_d = `LIDC_VEC_DEBUG;
                        iip_d = branch_target;
                    end else if (single_step_enable || legacy_trap_flag || (|trap_bits_q)) begin
                        exc_valid_d = 1'b1;
                        exc_vec_d = `LIDC_VEC_DEBUG;
                        iip_d = next_ip;
                    end
                    exc_kind_d = lidc_pkg::LIDC_EXC_NONE;
                    if (!exc_valid_d) begin
                        trap_bits_d = '0;
                    end
                end else if (exc_valid_q) begin
                    trap_bits_d = '0;
                end
            end
            lidc_pkg::LIDC_ST_ISSUE: begin
                st_d = lidc_pkg::LIDC_ST_IDLE;
            end
            lidc_pkg::LIDC_ST_WAIT: begin
                if (fabric_accept) begin
                    if (rem_len_q != 3'd0) begin
                        fab_addr_d = rem_addr_q;
                        fab_len_d = rem_len_q;
                        rem_len_d = 3'd0;
                    end else begin
                        st_d = lidc_pkg::LIDC_ST_IDLE;
                    end
                end
            end
            default: begin
                st_d = lidc_pkg::LIDC_ST_IDLE;
            end
        endcase
    end

    // Registers for the sequencer and report.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= lidc_pkg::LIDC_ST_IDLE;
            {rem_addr_q, rem_len_q, fab_addr_q, fab_len_q, fab_write_q, exc_valid_q, trap_bits_q, iip_q, id_q,
             rf_q} <= '0;
            exc_kind_q <= lidc_pkg::LIDC_EXC_NONE;
            exc_vec_q <= `LIDC_VEC_NONE;
        end else begin
            st_q <= st_d;
            {rem_addr_q, rem_len_q, fab_addr_q, fab_len_q, fab_write_q, exc_valid_q, trap_bits_q, iip_q, id_q,
             rf_q} <= {rem_addr_d, rem_len_d, fab_addr_d, fab_len_d, fab_write_d, exc_valid_d, trap_bits_d, iip_d,
             id_d, rf_d};
            exc_kind_q <= exc_kind_d;
            exc_vec_q <= exc_vec_d;
        end
    end

    // Outputs.
    assign fab_valid = !idle;
    assign fab_addr = fab_addr_q;
    assign fab_len = fab_len_q;
    assign fab_write = fab_write_q;
    assign acc_busy = (st_q == lidc_pkg::LIDC_ST_WAIT);
    assign exc_valid = exc_valid_q;
    assign exc_kind = exc_kind_q;
    assign exc_vector = exc_vec_q;
    assign exc_trap_bits = trap_bits_q;
    assign interruption_instr_pointer = iip_q;
    assign lower_priv_trap = 1'b0;
    assign instr_debug_suppress = id_q;
    assign legacy_resume_flag = rf_q;

    // A port instruction holds the sequencer until the fabric accepts.
    wait_accept_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == lidc_pkg::LIDC_ST_WAIT && !fabric_accept) |=> st_q == lidc_pkg::LIDC_ST_WAIT)
        else $error("port wait left early");
    gp_priv_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (idle && acc_req && acc_is_port && !priv_ok && !io_bitmap_enable
         && !ibrk) |=> exc_valid && exc_kind == lidc_pkg::LIDC_EXC_GP)
        else $error("no fault on privilege failure");
    no_bitmap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!io_bitmap_enable || priv_ok) |-> !bitmap_rd)
        else $error("bitmap read not allowed");
    plain_ls_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (idle && acc_req && !acc_is_port && pre_exc == lidc_pkg::LIDC_EXC_NONE
         && !ibrk) |=> st_q == lidc_pkg::LIDC_ST_ISSUE ##1 idle)
        else $error("plain access waited");
    split_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
        fab_valid |-> (fab_len != 3'd0 && fab_len <= 3'd4))
        else $error("bad transaction length");
    step_trap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (idle && retire_legacy && single_step_enable && !acc_req
         && !ibrk && !retire_break3 && !(taken_branch_trap_enable && retire_taken_branch))
        |=> exc_valid && interruption_instr_pointer == $past(next_ip))
        else $error("no step trap");
    ibrk_supp_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (id_q || rf_q || !debug_enable) |=> !(exc_valid && exc_kind == lidc_pkg::LIDC_EXC_IBRK))
        else $error("fault while suppressed");
    supp_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (retire_legacy && !set_instr_debug_suppress && !set_legacy_resume_flag) |=> (!id_q && !rf_q))
        else $error("suppress not cleared");
    branch_trap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (idle && retire_legacy && taken_branch_trap_enable && retire_taken_branch
         && !retire_break3 && !acc_req && !ibrk)
        |=> exc_valid && interruption_instr_pointer == $past(branch_target))
        else $error("bad branch trap");
endmodule : lidc_checks
`default_nettype wire

// ==== lidc_params.svh ====
// Constants for the legacy port and debug exception checks.
// Assumes inclusion by bare name.
`ifndef LIDC_PARAMS_SVH
`define LIDC_PARAMS_SVH
`define LIDC_VA_W 64
`define LIDC_PORT_W 16
`define LIDC_PL_W 2
`define LIDC_NBRK 4
`define LIDC_PAGE_SHIFT 12
`define LIDC_PORT_HI_LSB 2
`define LIDC_PORT_LO_MSB 11
`define LIDC_LEGACY_HI_LSB 32
`define LIDC_VEC_BREAK 8'h03
`define LIDC_VEC_DEBUG 8'h01
`define LIDC_VEC_GP 8'h0D
`define LIDC_VEC_ALIGN 8'h11
`define LIDC_VEC_NONE 8'h00
`endif

// ==== lidc_pkg.sv ====
// Types for the legacy port and debug exception checks.
// Assumes no surroundings beyond the compiler.
package lidc_pkg;
    typedef enum logic [3:0] {
        LIDC_EXC_NONE = 4'b0000,
        LIDC_EXC_GP = 4'b0001,
        LIDC_EXC_HPT_MISS = 4'b0010,
        LIDC_EXC_DTLB_MISS = 4'b0011,
        LIDC_EXC_ALT_DTLB_MISS = 4'b0100,
        LIDC_EXC_PROT = 4'b0101,
        LIDC_EXC_ALIGN = 4'b0110,
        LIDC_EXC_IBRK = 4'b0111
    } lidc_exc_t;
    typedef enum logic [1:0] {
        LIDC_ST_IDLE = 2'b00,
        LIDC_ST_ISSUE = 2'b01,
        LIDC_ST_WAIT = 2'b10
    } lidc_state_t;
endpackage : lidc_pkg

// ==== lidc_brk_match.sv ====
// One breakpoint comparator for legacy data or instruction addresses.
// Assumes a caller in the core clock domain.
`include "lidc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lidc_brk_match (
    // Breakpoint register contents.
    input wire logic [`LIDC_VA_W-1:0] bp_addr,
    input wire logic [`LIDC_VA_W-1:0] bp_mask,
    // Access under test.
    input wire logic [`LIDC_VA_W-1:0] acc_addr,
    input wire logic [2:0] acc_len,
    input wire logic is_instr,
    // Result.
    output logic hit
);
    logic [`LIDC_VA_W-1:0] mask_eff;
    logic [3:0] byte_hit;
    // Instruction matching drops mask bits above 31; data matching keeps them.
    assign mask_eff = is_instr ? {{(`LIDC_VA_W-`LIDC_LEGACY_HI_LSB){1'b0}},
                                  bp_mask[`LIDC_LEGACY_HI_LSB-1:0]} : bp_mask;
    // Each byte inside the access length is compared under the mask.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
            logic [`LIDC_VA_W-1:0] a;
            assign a = acc_addr + `LIDC_VA_W'(gi);
            assign byte_hit[gi] = ({29'd0, acc_len} > 32'(gi)) &&
                                  ((a & mask_eff) == (bp_addr & mask_eff));
        end
    endgenerate
    // Upper address bits must be zero for a legacy hit; instructions test only the first byte.
    assign hit = (bp_addr[`LIDC_VA_W-1:`LIDC_LEGACY_HI_LSB] == '0) &&
                 (is_instr ? byte_hit[0] : (|byte_hit));
endmodule : lidc_brk_match
`default_nettype wire

// ==== lidc_fabric_model.sv ====
// Fabric model: accepts each standing transaction after a chosen delay.
// Assumes requests stand until accepted.
`timescale 1ns/1ps
`default_nettype none
module lidc_fabric_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Transaction and pacing.
    input wire logic fab_valid,
    input wire logic [1:0] delay,
    output logic fabric_accept
);
    logic [1:0] wait_q;
    // Accept is a one-cycle pulse and never two in a row, so each piece is taken once.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {wait_q, fabric_accept} <= 3'h0;
        end else begin
            fabric_accept <= fab_valid && !fabric_accept && wait_q == delay;
            wait_q <= (fab_valid && !fabric_accept && wait_q != delay) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule : lidc_fabric_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the legacy port and debug checks.
// Assumes a 40 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk, sys_rst, io_bitmap_enable, data_translation_enable, alignment_check_enable, single_step_enable;
    logic legacy_trap_flag, debug_enable, taken_branch_trap_enable, fetch_valid, retire_legacy, retire_native;
    logic retire_break3, retire_taken_branch, set_instr_debug_suppress, set_legacy_resume_flag, acc_req;
    logic acc_is_port, acc_write, bitmap_deny, tlb_hit, hpt_walk_en, addr_implemented, tlb_prot_ok, fabric_accept;
    logic bitmap_rd, fab_valid, fab_write, acc_busy, exc_valid, lower_priv_trap, instr_debug_suppress;
    logic legacy_resume_flag;
    logic [1:0] current_privilege_level, io_privilege_level, delay;
    logic [2:0] acc_len, fab_len;
    logic [3:0] data_bp_rd_en, data_bp_wr_en, instr_bp_x_en, exc_trap_bits;
    logic [7:0] data_bp_plv, instr_bp_plv, exc_vector;
    logic [15:0] acc_port;
    logic [63:0] io_space_base, fetch_addr, next_ip, branch_target, acc_vaddr, fab_addr, dva;
    logic [63:0] interruption_instr_pointer;
    logic [255:0] data_bp_addr, data_bp_mask, instr_bp_addr, instr_bp_mask;
    lidc_pkg::lidc_exc_t exc_kind;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    localparam lidc_pkg::lidc_exc_t exc_none = lidc_pkg::LIDC_EXC_NONE, exc_gp = lidc_pkg::LIDC_EXC_GP;
    // Fault cases {translation, implemented, hit, walk, rights ok, align check} and their faults.
    localparam logic [5:0] fault_cfg [6] = '{6'h1A, 6'h2A, 6'h32, 6'h36, 6'h38, 6'h3B};
    localparam lidc_pkg::lidc_exc_t fault_kind [6] = '{exc_gp, exc_gp,
        lidc_pkg::LIDC_EXC_DTLB_MISS, lidc_pkg::LIDC_EXC_HPT_MISS, lidc_pkg::LIDC_EXC_PROT, lidc_pkg::LIDC_EXC_ALIGN};
    // Retire cases as {single step, trap flag, branch enable, break, taken branch}.
    localparam logic [4:0] step_cfg [5] = '{5'h10, 5'h09, 5'h05, 5'h02, 5'h01};

    lidc_checks u_lidc_checks (.*);
    lidc_fabric_model u_lidc_fabric_model (.mclk, .sys_rst, .fab_valid, .delay, .fabric_accept);

    // Core clock at 25 ns.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // One access; port accesses split at four-port groups.
    task automatic acc(input logic port, input logic [15:0] p, input logic [2:0] len, input lidc_pkg::lidc_exc_t ek);
        logic [15:0] q;
        logic [2:0] fl;
        int n;
        int k;
        @(posedge mclk);
        fl = (port && len > 3'h4 - p[1:0]) ? 3'h4 - p[1:0] : len;
        acc_req <= 1'b1;
        {acc_is_port, acc_port, acc_len, delay, acc_write} <= {port, p, len, 2'(1 + $urandom % 3), port & 1'($urandom)};
        @(negedge mclk);
        chk("bitmap_rd", bitmap_rd, port && io_bitmap_enable && current_privilege_level > io_privilege_level);
        @(posedge mclk);
        acc_req <= 1'b0;
        @(negedge mclk);
        chk("exc_valid", exc_valid, ek != exc_none);
        if (ek != exc_none) begin
            chk("exc_kind", exc_kind, ek);
            chk("exc_vector", exc_vector, ek == exc_gp ? 8'h0D : ek == lidc_pkg::LIDC_EXC_ALIGN ? 8'h11 : 8'h00);
        end else chk("fab_write", fab_write, acc_write);
        chk("acc_busy", acc_busy, port && ek == exc_none);
        n = 0;
        k = 0;
        while (fab_valid === 1'b1 && n < 40) begin
            q = p + (k ? fl : 3'h0);
            chk("fab_addr", fab_addr, port ? io_space_base | {q[15:2], 12'h000} | q[11:0] : acc_vaddr);
            chk("fab_len", fab_len, k ? len - fl : fl);
            k += fabric_accept;
            n++;
            @(negedge mclk);
        end
        chk("pieces", k, (port && ek == exc_none) ? 1 + (len > fl) : 0);
    endtask : acc

    // One legacy retirement and its expected trap.
    task automatic ret(input logic b3, input logic br, input logic pend);
        logic ptr;
        @(posedge mclk);
        ptr = single_step_enable || legacy_trap_flag || (br && taken_branch_trap_enable);
        {retire_legacy, retire_break3, retire_taken_branch} <= {1'b1, b3, br};
        {next_ip, branch_target} <= {32'h0, $urandom, 32'h0, $urandom};
        @(posedge mclk);
        {retire_legacy, retire_break3, retire_taken_branch} <= 3'h0;
        @(negedge mclk);
        chk("exc_valid", exc_valid, b3 || ptr || pend);
        if (b3 || ptr || pend) chk("exc_vector", exc_vector, b3 ? 8'h03 : 8'h01);
        if (ptr && !b3) chk("pointer", interruption_instr_pointer, br && taken_branch_trap_enable ? branch_target : next_ip);
    endtask : ret

    task automatic fetch(input logic hit);
        @(posedge mclk);
        {fetch_valid, fetch_addr} <= {1'b1, dva + 64'h1};
        @(posedge mclk);
        fetch_valid <= 1'b0;
        @(negedge mclk);
        chk("ibrk", exc_valid && exc_kind === lidc_pkg::LIDC_EXC_IBRK, hit);
    endtask : fetch

    // Main sequence.
    initial begin
        void'($urandom(75));
        {sys_rst, data_translation_enable, addr_implemented, tlb_hit, tlb_prot_ok} = 5'h1F;
        {io_bitmap_enable, alignment_check_enable, single_step_enable, legacy_trap_flag, debug_enable} = '0;
        {taken_branch_trap_enable, fetch_valid, retire_legacy, retire_native, retire_break3, retire_taken_branch} = '0;
        {set_instr_debug_suppress, set_legacy_resume_flag, acc_req, acc_is_port, acc_write, bitmap_deny} = '0;
        {hpt_walk_en, current_privilege_level, io_privilege_level, delay, acc_len, acc_port, dva} = '0;
        {data_bp_rd_en, data_bp_wr_en, instr_bp_x_en, data_bp_plv, instr_bp_plv, fetch_addr, next_ip} = '0;
        {branch_target, acc_vaddr, data_bp_addr, data_bp_mask, instr_bp_addr, instr_bp_mask} = '0;
        io_space_base = {32'($urandom), 6'($urandom), 26'h000_0000};
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        io_privilege_level <= 2'h3;
        for (int i = 0; i < 12; i++) begin
            current_privilege_level <= 2'($urandom);
            acc(1'b1, 16'($urandom), 3'(1 << ($urandom % 3)), exc_none);
        end
        {current_privilege_level, io_privilege_level} <= 4'hC;
        for (int i = 0; i < 3; i++) begin
            {io_bitmap_enable, bitmap_deny} <= {i != 2, i == 1};
            acc(1'b1, 16'($urandom), 3'h1, i == 0 ? exc_none : exc_gp);
        end
        {current_privilege_level, io_privilege_level, io_bitmap_enable} <= 5'h06;
        for (int i = 0; i < 7; i++) begin
            {data_translation_enable, addr_implemented, tlb_hit, hpt_walk_en, tlb_prot_ok,
                alignment_check_enable} <= i == 6 ? 6'h3A : fault_cfg[i];
            if (i < 6) acc(1'b1, 16'h0041, 3'h2, fault_kind[i]);
        end
        @(posedge mclk);
        dva = {32'h0, $urandom & 32'hFFFF_FFF0};
        {current_privilege_level, io_privilege_level, debug_enable, acc_vaddr} <= {4'hC, 1'b1, dva};
        {data_bp_addr, data_bp_mask} <= {{4{dva + 64'h3}}, {4{64'hFFFF_FFFF_FFFF_FFFF}}};
        {data_bp_rd_en, data_bp_plv} <= {4'h7, 8'hF3};
        acc(1'b0, 16'h0000, 3'h4, exc_none);
        ret(1'b0, 1'b0, 1'b1);
        chk("trap_bits", exc_trap_bits, 4'h5);
        for (int i = 0; i < 5; i++) begin
            {single_step_enable, legacy_trap_flag, taken_branch_trap_enable} <= step_cfg[i][4:2];
            ret(step_cfg[i][1], step_cfg[i][0], 1'b0);
        end
        {instr_bp_addr, instr_bp_x_en, instr_bp_plv} <= {{4{dva}}, 4'h1, 8'hFF};
        instr_bp_mask <= {4{64'hFFFF_FFFF_FFFF_FFFC}};
        fetch(1'b1);
        @(posedge mclk);
        set_legacy_resume_flag <= 1'b1;
        @(posedge mclk);
        set_legacy_resume_flag <= 1'b0;
        fetch(1'b0);
        ret(1'b0, 1'b0, 1'b0);
        chk("resume", legacy_resume_flag, 1'b0);
        fetch(1'b1);
        @(posedge mclk);
        {set_instr_debug_suppress, retire_native} <= 2'h2;
        @(posedge mclk);
        {set_instr_debug_suppress, retire_native} <= 2'h1;
        @(negedge mclk);
        chk("suppress", instr_debug_suppress, 1'b1);
        @(posedge mclk);
        retire_native <= 1'b0;
        @(negedge mclk);
        chk("suppress", instr_debug_suppress, 1'b0);
        chk("lower_priv", lower_priv_trap, 1'b0);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
